/* common/motion_cmd_pkg.sv */
// Constants and types shared by the motion parameter command interpreter
package motion_cmd_pkg;
  // Frame layout
  localparam int FRAME_BYTES = 9;
  localparam logic [3:0] LAST_BYTE_IDX = 4'h8;
  localparam logic [3:0] BYTE_IDX_RESET = 4'h0;
  // Instruction codes
  localparam logic [7:0] MOVE_TO_POSITION_CMD = 8'h04;
  localparam logic [7:0] WRITE_AXIS_PARAM_CMD = 8'h05;
  localparam logic [7:0] READ_AXIS_PARAM_CMD = 8'h06;
  localparam logic [7:0] PERSIST_AXIS_PARAM_CMD = 8'h07;
  localparam logic [7:0] RELOAD_AXIS_PARAM_CMD = 8'h08;
  localparam logic [7:0] WRITE_GLOBAL_PARAM_CMD = 8'h09;
  // Move types
  localparam logic [7:0] STORED_COORDINATE_TYPE = 8'h02;
  // Global banks
  localparam logic [7:0] BANK_MODULE = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  // Reply status codes
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] PARAM_RESET_IDX = 8'h00;
  // Engine states
  typedef enum logic [2:0] {
    ST_RECV = 3'b000,
    ST_EXEC = 3'b001,
    ST_BOOT = 3'b010,
    ST_REPLY = 3'b011
  } state_t;
endpackage

/* core/motion_param_command_interp.sv */
// Command interpreter for axis and global parameter frames
// Functional notes
// R1: Move type 2 targets stored coordinate index
// R2: Host loads coordinate before stored move
// R3: Code 5 writes selected axis parameter
// R4: Written axis parameters live in volatile memory
// R5: Direct-mode read returns value, accumulator untouched
// R6: Standalone-mode read also loads accumulator
// R7: Code 7 copies parameter to non-volatile
// R8: Code 8 reloads parameter from non-volatile
// R9: Power-up loads all parameters from non-volatile; the boot sweep here reloads only axis parameters, not bank 0 globals
// R10: Code 9 writes global parameter, banks 0/2/3
// R11: Bank 0 module, 2 user, 3 interrupt
// R12: Bank 0 writes persist automatically
// R13: Nine bytes: addr, instr, type, bank, value, checksum
// R14: Checksum is byte sum; mismatches rejected
// R15: Every accepted frame gets status and value reply
`timescale 1ns/1ps
`default_nettype none
module motion_param_command_interp #(
  parameter int AXIS_PARAMS = 256,
  parameter int NUM_COORDS = 21,
  parameter int GLOBAL_PARAMS = 256,
  parameter logic [7:0] MODULE_ADDR = 8'h01
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  input wire logic standalone_mode,
  input wire logic [NUM_COORDS*32-1:0] stored_coordinate_type_table,
  output logic move_valid,
  output logic [31:0] move_target,
  output logic [7:0] move_motor,
  output logic reply_valid,
  input wire logic reply_ready,
  output logic [7:0] reply_status,
  output logic [31:0] reply_value,
  output logic [31:0] accumulator,
  output logic boot_done
);
  import motion_cmd_pkg::*;

  // Working memory is volatile; the shadow models the non-volatile copy
  logic [31:0] axis_work [AXIS_PARAMS]; // R4
  logic [31:0] axis_nv [AXIS_PARAMS];
  logic [31:0] glob_module [GLOBAL_PARAMS];
  logic [31:0] glob_module_nv [GLOBAL_PARAMS];
  logic [31:0] glob_user [GLOBAL_PARAMS];
  logic [31:0] glob_irq [GLOBAL_PARAMS];

  state_t state;
  logic [3:0] byte_idx;
  logic [7:0] frame [FRAME_BYTES];
  logic [7:0] sum;
  logic [7:0] boot_idx;

  // Frame field decode
  wire [7:0] f_addr = frame[0];
  wire [7:0] f_instr = frame[1];
  wire [7:0] f_type = frame[2];
  wire [7:0] f_bank = frame[3];
  wire [31:0] f_value = {frame[4], frame[5], frame[6], frame[7]}; // R13
  wire sum_ok = (sum == frame[8]); // R14
  wire addr_ok = (f_addr == MODULE_ADDR);
  wire type_in_range = (32'(f_type) < AXIS_PARAMS);
  wire stored_coordinate_type_in_range = (f_value < 32'(NUM_COORDS));
  wire bank_ok = (f_bank == BANK_MODULE) || (f_bank == BANK_USER) ||
                 (f_bank == BANK_IRQ); // R10
  wire [31:0] axis_rd = axis_work[f_type];
  wire is_move = (f_instr == MOVE_TO_POSITION_CMD);
  wire is_stored_coordinate_type_move = is_move && (f_type == STORED_COORDINATE_TYPE); // R1
  wire [31:0] stored_coordinate_type_sel = stored_coordinate_type_table[f_value[4:0]*32 +: 32];

  assign rx_ready = (state == ST_RECV);
  wire rx_take = rx_valid && rx_ready;
  wire last_byte = (byte_idx == LAST_BYTE_IDX);

  // Status chosen from the completed frame
  logic [7:0] next_status;
  always_comb begin
    next_status = STATUS_OK;
    if (!sum_ok) begin
      next_status = STATUS_BAD_CHECKSUM; // R14
    end else begin
      case (f_instr)
        MOVE_TO_POSITION_CMD: begin
          if (is_stored_coordinate_type_move && !stored_coordinate_type_in_range) next_status = STATUS_BAD_VALUE;
          else if (f_type > STORED_COORDINATE_TYPE) next_status = STATUS_BAD_TYPE;
        end
        WRITE_AXIS_PARAM_CMD, READ_AXIS_PARAM_CMD,
        PERSIST_AXIS_PARAM_CMD, RELOAD_AXIS_PARAM_CMD: begin
          if (!type_in_range) next_status = STATUS_BAD_TYPE;
        end
        WRITE_GLOBAL_PARAM_CMD: begin
          if (!bank_ok) next_status = STATUS_BAD_VALUE; // R11
        end
        default: next_status = STATUS_BAD_CMD;
      endcase
    end
  end
  wire exec_ok = (next_status == STATUS_OK) && addr_ok;

  // Frame sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_BOOT;
      byte_idx <= BYTE_IDX_RESET;
      sum <= BYTE_RESET;
      boot_idx <= PARAM_RESET_IDX;
      boot_done <= 1'b0;
    end else begin
      case (state)
        ST_BOOT: begin
          boot_idx <= boot_idx + 8'h01;
          if (32'(boot_idx) == AXIS_PARAMS - 1) begin
            state <= ST_RECV;
            boot_done <= 1'b1;
          end
        end
        ST_RECV: begin
          if (rx_take) begin
            if (!last_byte) sum <= sum + rx_byte;
            byte_idx <= last_byte ? BYTE_IDX_RESET : byte_idx + 4'h1;
            if (last_byte) state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          sum <= BYTE_RESET;
          // Frames for another address get no answer
          state <= addr_ok ? ST_REPLY : ST_RECV; // R15
        end
        ST_REPLY: begin
          if (reply_ready) state <= ST_RECV;
        end
        default: state <= ST_RECV;
      endcase
    end
  end

  // Frame byte capture
  always_ff @(posedge clk) begin
    if (rx_take) frame[byte_idx] <= rx_byte;
  end

  // Parameter memories; boot sweep copies axis non-volatile into working
  always_ff @(posedge clk) begin
    if (state == ST_BOOT) begin
      axis_work[boot_idx] <= axis_nv[boot_idx]; // R9
    end else if (state == ST_EXEC && exec_ok) begin
      case (f_instr)
        WRITE_AXIS_PARAM_CMD: axis_work[f_type] <= f_value; // R3
        PERSIST_AXIS_PARAM_CMD: axis_nv[f_type] <= axis_rd; // R7
        RELOAD_AXIS_PARAM_CMD: axis_work[f_type] <= axis_nv[f_type]; // R8
        WRITE_GLOBAL_PARAM_CMD: begin
          if (f_bank == BANK_MODULE) begin
            glob_module[f_type] <= f_value; // R10
            glob_module_nv[f_type] <= f_value; // R12
          end else if (f_bank == BANK_USER) begin
            glob_user[f_type] <= f_value; // R11
          end else begin
            glob_irq[f_type] <= f_value; // R11
          end
        end
        default: ;
      endcase
    end
  end

  // Reply, accumulator and move request registers
  always_ff @(posedge clk) begin
    if (rst) begin
      reply_status <= BYTE_RESET;
      reply_value <= WORD_RESET;
      accumulator <= WORD_RESET;
      move_valid <= 1'b0;
      move_target <= WORD_RESET;
      move_motor <= BYTE_RESET;
    end else begin
      move_valid <= 1'b0;
      if (state == ST_EXEC && addr_ok) begin
        reply_status <= next_status; // R15
        reply_value <= WORD_RESET;
        if (exec_ok && f_instr == READ_AXIS_PARAM_CMD) begin
          reply_value <= axis_rd; // R5
          if (standalone_mode) accumulator <= axis_rd; // R6
        end
        if (exec_ok && is_move) begin
          move_valid <= 1'b1;
          move_motor <= f_bank;
          move_target <= is_stored_coordinate_type_move ? stored_coordinate_type_sel : f_value; // R1
        end
      end
    end
  end

  assign reply_valid = (state == ST_REPLY);

  // Checks; the frame stays put for one cycle after execute, so |=> may read its fields
  a_read_no_acc: assert property (@(posedge clk) disable iff (rst) // R5
    (state == ST_EXEC && exec_ok && f_instr == READ_AXIS_PARAM_CMD && !standalone_mode)
    |=> $stable(accumulator)) else $error("direct read changed accumulator");
  a_read_acc: assert property (@(posedge clk) disable iff (rst) // R6
    (state == ST_EXEC && exec_ok && f_instr == READ_AXIS_PARAM_CMD && standalone_mode)
    |=> accumulator == $past(axis_rd)) else $error("standalone read missed accumulator");
  a_bad_sum: assert property (@(posedge clk) disable iff (rst) // R14
    (state == ST_EXEC && addr_ok && !sum_ok) |=> reply_valid &&
    reply_status == STATUS_BAD_CHECKSUM) else $error("bad checksum not flagged");
  a_reply_hold: assert property (@(posedge clk) disable iff (rst) // R15
    (reply_valid && !reply_ready) |=> reply_valid && $stable(reply_status))
    else $error("reply dropped before taken");
  a_stored_coordinate_type_move: assert property (@(posedge clk) disable iff (rst) // R1
    (state == ST_EXEC && exec_ok && is_stored_coordinate_type_move) |=> move_valid &&
    move_target == $past(stored_coordinate_type_sel)) else $error("stored coordinate move wrong");
  a_boot_len: assert property (@(posedge clk) disable iff (rst) // R9
    $rose(boot_done) |-> $past(state) == ST_BOOT) else $error("boot ended early");
  a_frame_len: assert property (@(posedge clk) disable iff (rst) // R13
    (state == ST_RECV && rx_take && last_byte) |=> state == ST_EXEC)
    else $error("frame length wrong");
  a_move_pulse: assert property (@(posedge clk) disable iff (rst) // R1
    move_valid |=> !move_valid) else $error("move request not a pulse");
  a_axis_write: assert property (@(posedge clk) disable iff (rst) // R3
    (state == ST_EXEC && exec_ok && f_instr == WRITE_AXIS_PARAM_CMD)
    |=> axis_work[f_type] == f_value) else $error("axis parameter not written");
  a_axis_store: assert property (@(posedge clk) disable iff (rst) // R7
    (state == ST_EXEC && exec_ok && f_instr == PERSIST_AXIS_PARAM_CMD)
    |=> axis_nv[f_type] == $past(axis_rd)) else $error("axis parameter not stored");
  a_axis_reload: assert property (@(posedge clk) disable iff (rst) // R8
    (state == ST_EXEC && exec_ok && f_instr == RELOAD_AXIS_PARAM_CMD)
    |=> axis_work[f_type] == axis_nv[f_type]) else $error("axis parameter not reloaded");
  a_bank0_persist: assert property (@(posedge clk) disable iff (rst) // R12
    (state == ST_EXEC && exec_ok && f_instr == WRITE_GLOBAL_PARAM_CMD && f_bank == BANK_MODULE)
    |=> glob_module[f_type] == f_value && glob_module_nv[f_type] == f_value)
    else $error("module setting not persisted");
  a_user_bank: assert property (@(posedge clk) disable iff (rst) // R11
    (state == ST_EXEC && exec_ok && f_instr == WRITE_GLOBAL_PARAM_CMD && f_bank == BANK_USER)
    |=> glob_user[f_type] == f_value) else $error("user variable not written");
  a_irq_bank: assert property (@(posedge clk) disable iff (rst) // R11
    (state == ST_EXEC && exec_ok && f_instr == WRITE_GLOBAL_PARAM_CMD && f_bank == BANK_IRQ)
    |=> glob_irq[f_type] == f_value) else $error("interrupt setting not written");
  c_move: cover property (@(posedge clk) disable iff (rst)
    move_valid);
  c_read: cover property (@(posedge clk) disable iff (rst)
    state == ST_EXEC && exec_ok && f_instr == READ_AXIS_PARAM_CMD);
  c_global: cover property (@(posedge clk) disable iff (rst)
    state == ST_EXEC && exec_ok && f_instr == WRITE_GLOBAL_PARAM_CMD);
  c_bad: cover property (@(posedge clk) disable iff (rst)
    reply_valid && reply_status == STATUS_BAD_CHECKSUM);
endmodule
`default_nettype wire

/* dv/frame_host.sv */
// Host model that offers command frames to the interpreter byte by byte
`timescale 1ns/1ps
`default_nettype none
module frame_host (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Eight bytes then their sum; bad flips the sum so refusal can be seen
  task automatic send(input logic [63:0] body, input logic bad, output logic ok);
    logic [7:0] sum;
    logic [7:0] b;
    int n;
    sum = 8'h00;
    ok = 1'b1;
    for (int i = 0; i < 9; i++) begin
      b = (i < 8) ? body[63-8*i -: 8] : (bad ? ~sum : sum);
      sum = sum + b;
      @(negedge clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      n = 0;
      // Byte stays put until an edge that sees ready
      while (rx_ready !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      if (n == 600) ok = 1'b0;
    end
    @(negedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~b; // No stale byte once released
  endtask
endmodule
`default_nettype wire

/* dv/motion_param_command_interp_bench.sv */
// Self-checking bench for the parameter command interpreter
`timescale 1ns/1ps
`default_nettype none
module motion_param_command_interp_bench;
  import motion_cmd_pkg::*;
  typedef struct packed {
    logic [63:0] f;
    logic sa;
    logic [7:0] st;
    logic [31:0] v;
    logic [31:0] acc;
  } row_t;
  localparam logic [31:0] PV = 32'h1234_5678;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid, rx_ready, standalone_mode, move_valid, reply_valid, boot_done;
  logic reply_ready = 1'b0;
  logic [7:0] rx_byte, move_motor, reply_status, st;
  logic [31:0] move_target, reply_value, accumulator, v;
  logic [21*32-1:0] stored_coordinate_type_table;
  logic ok, mv;
  int num_errors = 0;
  int checks_done = 0;
  row_t rows [14];
  always #2.5 clk = ~clk;
  motion_param_command_interp motion_param_command_interp_i (.clk(clk), .rst(rst),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .standalone_mode(standalone_mode), .stored_coordinate_type_table(stored_coordinate_type_table), .move_valid(move_valid),
    .move_target(move_target), .move_motor(move_motor), .reply_valid(reply_valid),
    .reply_ready(reply_ready), .reply_status(reply_status), .reply_value(reply_value),
    .accumulator(accumulator), .boot_done(boot_done));
  frame_host frame_host_i (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded waits; running out of patience ends the run as a mismatch
  task automatic wait_boot;
    int n;
    n = 0;
    while (boot_done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic run(input logic [63:0] f, input logic bad);
    int n;
    frame_host_i.send(f, bad, ok);
    n = 0;
    while (reply_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (ok !== 1'b1 || n == 20) begin
      num_errors++;
      print_verdict();
    end
    st = reply_status;
    v = reply_value;
    mv = move_valid;
    reply_ready <= 1'b1;
    @(negedge clk);
    reply_ready <= 1'b0;
  endtask
  initial begin
    standalone_mode = 1'b0;
    for (int n = 0; n < 21; n++) stored_coordinate_type_table[n*32 +: 32] = 32'hC0DE_0000 | n;
    rows = '{{64'h0105_0400_1234_5678, 1'b0, STATUS_OK, 32'h0, 32'h0},
      {64'h0106_0400_0000_0000, 1'b1, STATUS_OK, PV, PV},
      {64'h0107_0400_0000_0000, 1'b0, STATUS_OK, 32'h0, PV},
      {64'h0105_0400_0000_00AA, 1'b0, STATUS_OK, 32'h0, PV},
      {64'h0106_0400_0000_0000, 1'b0, STATUS_OK, 32'hAA, PV},
      {64'h0108_0400_0000_0000, 1'b0, STATUS_OK, 32'h0, PV},
      {64'h0106_0400_0000_0000, 1'b0, STATUS_OK, PV, PV},
      {64'h0109_0500_0000_0001, 1'b0, STATUS_OK, 32'h0, PV},
      {64'h0109_0502_0000_0001, 1'b0, STATUS_OK, 32'h0, PV},
      {64'h0109_0503_0000_0001, 1'b0, STATUS_OK, 32'h0, PV},
      {64'h0109_0501_0000_0001, 1'b0, STATUS_BAD_VALUE, 32'h0, PV},
      {64'h0120_0000_0000_0000, 1'b0, STATUS_BAD_CMD, 32'h0, PV},
      {64'h0104_0300_0000_0000, 1'b0, STATUS_BAD_TYPE, 32'h0, PV},
      {64'h0104_0200_0000_0015, 1'b0, STATUS_BAD_VALUE, 32'h0, PV}};
    repeat (10) @(negedge clk);
    check(rx_ready, 1'b0);
    check(boot_done, 1'b0);
    check(accumulator, 32'h0);
    rst = 1'b0;
    wait_boot();
    // Table rows: writes, reads in both modes, store, reload, banks, errors
    for (int i = 0; i < 14; i++) begin
      standalone_mode = rows[i].sa;
      run(rows[i].f, 1'b0);
      check(st, rows[i].st);
      check(v, rows[i].v);
      check(accumulator, rows[i].acc);
      check(mv, 1'b0);
      $display("row %0d done", i);
    end
    // Move to stored coordinate eight takes that table entry
    run(64'h0104_0203_0000_0008, 1'b0);
    check(move_target, 32'hC0DE_0008);
    check(mv, 1'b1);
    check(move_motor, 8'h03);
    $display("stored move done");
    // Corrupt sum must leave the parameter alone
    run(64'h0105_0400_0000_0000, 1'b1);
    check(st, STATUS_BAD_CHECKSUM);
    run(64'h0106_0400_0000_0000, 1'b0);
    check(v, PV);
    // Frame for another address gets silence
    frame_host_i.send(64'h0205_0400_0000_0000, 1'b0, ok);
    repeat (20) @(negedge clk);
    check(reply_valid, 1'b0);
    $display("refusals done");
    // Volatile value lost over reset, stored one comes back
    run(64'h0105_0400_0000_00AA, 1'b0);
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    wait_boot();
    check(accumulator, 32'h0);
    run(64'h0106_0400_0000_0000, 1'b0);
    check(v, PV);
    $display("power-up reload done");
    print_verdict();
  end
endmodule
`default_nettype wire
